// ==== include/dsrt_map.svh ====
`ifndef DSRT_MAP_SVH
`define DSRT_MAP_SVH
// error field bit positions
`define DSRT_ERR_SOT 0
`define DSRT_ERR_SOT_SYNC 1
`define DSRT_ERR_EOT_SYNC 2
`define DSRT_ERR_ESC 3
`define DSRT_ERR_LP_SYNC 4
`define DSRT_ERR_HS_TMO 5
`define DSRT_ERR_FALSE_CTL 6
`define DSRT_ERR_ECC1 8
`define DSRT_ERR_ECC2 9
`define DSRT_ERR_CKSUM 10
`define DSRT_ERR_DTYPE 11
`define DSRT_ERR_VC 12
`define DSRT_ERR_MASK 16'h1F7F
// response data types
`define DSRT_DT_ACK_ERR 6'h02
`define DSRT_DT_GEN_RD1 6'h11
`define DSRT_DT_GEN_RD2 6'h12
`define DSRT_DT_GEN_LONG 6'h1A
`define DSRT_DT_DCS_LONG 6'h1C
`define DSRT_DT_DCS_RD1 6'h21
`define DSRT_DT_DCS_RD2 6'h22
// incoming data types
`define DSRT_DT_DCS_SW1 6'h15
`define DSRT_DT_DCS_SW0 6'h05
`define DSRT_DT_DCS_LW 6'h39
`define DSRT_DT_CMP_MODE 6'h07
`define DSRT_DT_PPS 6'h0A
`define DSRT_DT_CMP_PIX 6'h0B
// display commands
`define DSRT_CMD_TEAR_OFF 8'h34
`define DSRT_CMD_TEAR_ON 8'h35
`define DSRT_CMD_TEAR_LINE 8'h44
// register byte addresses
`define DSRT_REG_CTRL 8'h00
`define DSRT_REG_STATUS 8'h04
`define DSRT_REG_ERR 8'h08
`define DSRT_REG_RDDATA 8'h0C
`define DSRT_REG_TEAR 8'h10
`define DSRT_REG_CMP 8'h14
`define DSRT_REG_PPS 8'h18
`define DSRT_REG_TX 8'h1C
// tear pulse width in ns and core cycles
`define DSRT_TEAR_PULSE_NS 80
`define DSRT_CLK_NS 40
`define DSRT_TEAR_PULSE_CYC ((`DSRT_TEAR_PULSE_NS + `DSRT_CLK_NS - 1) / `DSRT_CLK_NS)
`endif

// ==== include/dsrt_pkg.sv ====
package dsrt_pkg;
  typedef enum {
    DSRT_IDLE, DSRT_HDR, DSRT_PAY, DSRT_CKS, DSRT_ERRPKT, DSRT_WAIT
  } dsrt_tx_e;
  typedef logic [7:0] dsrt_byte_t;
endpackage

// ==== include/dsrt_pps_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// write and read path of the parameter table store
interface dsrt_pps_if #(parameter int AW = 8);
  logic we;
  logic [AW-1:0] waddr;
  logic [7:0] wdata;
  logic [AW-1:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// ==== logic/dsrt_pps_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
module dsrt_pps_mem #(
  parameter int AW = 8
) (
  input wire logic aclk,
  dsrt_pps_if.mem pps
);
  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] rd;
  // registered read and write
  always_ff @(posedge aclk) begin
    if (pps.we) begin
      mem[pps.waddr] <= pps.wdata;
    end
    rd <= mem[pps.raddr];
  end
  assign pps.rdata = rd;
endmodule // dsrt_pps_mem
`default_nettype wire

// ==== logic/dsrt_response_tear.sv ====
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "dsrt_map.svh"
module dsrt_response_tear #(
  parameter int PPS_AW = 8,
  parameter int MAX_RD = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  // packet receiver side
  input wire logic rx_valid,
  input wire logic [5:0] rx_dtype,
  input wire logic [1:0] rx_vc,
  input wire logic [15:0] rx_hdr_data,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_end,
  input wire logic [15:0] rx_err,
  input wire logic bta_grant,
  input wire logic lp_mode,
  input wire logic lane_clk,
  // display timing
  input wire logic vsync,
  input wire logic hsync,
  // reverse byte stream on lane 0, tear output, decompression mode and command discard flag
  output logic lane0_valid,
  output logic [7:0] lane0_byte,
  output logic lane0_last,
  output logic tear_sync_output,
  output logic decomp_enable,
  output logic [1:0] decomp_algo,
  output logic [1:0] decomp_table,
  output logic cmd_discard,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import dsrt_pkg::*;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // packet header ecc over 24 header bits
  function automatic logic [7:0] hdr_ecc(input logic [23:0] d);
    logic [5:0] p;
    p[0] = ^(d & 24'hF12CB7);
    p[1] = ^(d & 24'hF2555B);
    p[2] = ^(d & 24'h749A6D);
    p[3] = ^(d & 24'hB8E38E);
    p[4] = ^(d & 24'hDF03F0);
    p[5] = ^(d & 24'hEFFC00);
    return {2'b00, p};
  endfunction
  // crc16 step, polynomial x16+x12+x5+1, lsb first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ 16'h8408) : (r >> 1);
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] vs_s, hs_s, lck_s;
  logic vs_d, hs_d;
  always_ff @(posedge aclk) begin
    vs_s <= {vs_s[0], vsync};
    hs_s <= {hs_s[0], hsync};
    lck_s <= {lck_s[0], lane_clk};
    vs_d <= vs_s[1];
    hs_d <= hs_s[1];
  end
  wire vs_rise = vs_s[1] & ~vs_d;
  wire hs_rise = hs_s[1] & ~hs_d;

  // ---------------------------------------------------------------
  // register and control state
  // ---------------------------------------------------------------
  logic [15:0] err_acc;
  logic tear_on, tear_mode;
  logic [15:0] tear_line;
  logic [7:0] cmp_pend, cmp_live;
  logic [31:0] rd_ctrl;
  logic [7:0] rd_word [0:3];
  logic [PPS_AW-1:0] pps_ptr, pps_raddr;
  logic pps_wr;
  logic [15:0] tx_count;
  dsrt_pps_if #(.AW(PPS_AW)) pps_bus ();

  dsrt_pps_mem #(.AW(PPS_AW)) u_pps (
    .aclk(aclk),
    .pps(pps_bus)
  );

  // incoming packet classification
  wire err_uncorr = |(rx_err & 16'h0203);
  wire is_sw1 = rx_valid & (rx_dtype == `DSRT_DT_DCS_SW1);
  wire is_sw0 = rx_valid & (rx_dtype == `DSRT_DT_DCS_SW0);
  wire is_lw = rx_valid & (rx_dtype == `DSRT_DT_DCS_LW);
  wire is_cmp = rx_valid & (rx_dtype == `DSRT_DT_CMP_MODE);
  wire is_pps = rx_valid & (rx_dtype == `DSRT_DT_PPS) & (rx_hdr_data != 16'h0000);
  wire exec_ok = ~err_uncorr;
  assign cmd_discard = rx_valid & err_uncorr;
  logic lw_tear;
  logic [1:0] lw_cnt;

  // ---------------------------------------------------------------
  // tear command decode
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tear_on <= 1'b0;
      tear_mode <= 1'b0;
      tear_line <= 16'h0000;
      lw_tear <= 1'b0;
      lw_cnt <= 2'b00;
    end else begin
      if (exec_ok & is_sw1 & (rx_hdr_data[7:0] == `DSRT_CMD_TEAR_ON)) begin
        tear_on <= 1'b1;
        tear_mode <= rx_hdr_data[8];
      end
      if (exec_ok & (is_sw0 | is_sw1) & (rx_hdr_data[7:0] == `DSRT_CMD_TEAR_OFF)) begin
        tear_on <= 1'b0;
      end
      if (exec_ok & is_lw) begin
        lw_cnt <= 2'b00;
        lw_tear <= 1'b1;
      end else if (rx_byte_valid & lw_tear) begin
        lw_cnt <= lw_cnt + 2'd1;
        if (lw_cnt == 2'd0 && rx_byte != `DSRT_CMD_TEAR_LINE) begin
          lw_tear <= 1'b0;
        end
        if (lw_cnt == 2'd1) begin
          tear_line[15:8] <= rx_byte;
        end
        if (lw_cnt == 2'd2) begin
          tear_line[7:0] <= rx_byte;
          lw_tear <= 1'b0;
        end
      end
      if (rx_end & lw_tear) begin
        lw_tear <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // tear output generator
  // ---------------------------------------------------------------
  logic [15:0] line_cnt;
  logic [2:0] pulse_cnt;
  wire line_hit = tear_mode & (tear_line != 16'h0000) & hs_rise &
                  (line_cnt + 16'd1 == tear_line);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_cnt <= 16'h0000;
      pulse_cnt <= 3'd0;
    end else begin
      line_cnt <= vs_rise ? 16'h0000 : (hs_rise ? line_cnt + 16'd1 : line_cnt);
      if (line_hit) begin
        pulse_cnt <= 3'(`DSRT_TEAR_PULSE_CYC);
      end else if (pulse_cnt != 3'd0) begin
        pulse_cnt <= pulse_cnt - 3'd1;
      end
    end
  end
  logic next_tear;
  always_comb begin
    if (!tear_on) begin
      next_tear = 1'b0;
    end else if (!tear_mode) begin
      next_tear = vs_s[1];
    end else if (tear_line == 16'h0000) begin
      next_tear = vs_s[1] | hs_s[1];
    end else begin
      next_tear = pulse_cnt != 3'd0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tear_sync_output <= 1'b0;
    end else begin
      tear_sync_output <= next_tear;
    end
  end

  // ---------------------------------------------------------------
  // compression mode and parameter table
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_pend <= 8'h00;
      cmp_live <= 8'h00;
      pps_ptr <= '0;
    end else begin
      if (exec_ok & is_cmp) begin
        cmp_pend <= {2'b00, rx_hdr_data[5:4], 1'b0, rx_hdr_data[2:0]};
      end
      if (vs_rise) begin
        cmp_live <= cmp_pend;
      end
      if (exec_ok & is_pps) begin
        pps_ptr <= '0;
      end else if (pps_wr & rx_byte_valid) begin
        pps_ptr <= pps_ptr + 1'b1;
      end
    end
  end
  logic pps_active;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pps_active <= 1'b0;
    end else if (exec_ok & is_pps) begin
      pps_active <= 1'b1;
    end else if (rx_end) begin
      pps_active <= 1'b0;
    end
  end
  // table 0 only is writable here; other selectors leave the store untouched
  assign pps_wr = pps_active & (cmp_pend[5:4] == 2'b00);
  assign pps_bus.we = pps_wr & rx_byte_valid;
  assign pps_bus.waddr = pps_ptr;
  assign pps_bus.wdata = rx_byte;
  assign pps_bus.raddr = pps_raddr;
  assign decomp_enable = cmp_live[0];
  assign decomp_algo = cmp_live[2:1];
  assign decomp_table = cmp_live[5:4];

  // ---------------------------------------------------------------
  // reverse packet transmitter
  // ---------------------------------------------------------------
  dsrt_tx_e state;
  logic [7:0] hdr [0:3];
  logic [1:0] bidx;
  logic [15:0] pidx, crc;
  logic send_err, rd_pend;
  logic [15:0] err_snap;
  logic [1:0] rd_vc_q;
  wire [15:0] err_in = rx_valid ? (rx_err & `DSRT_ERR_MASK) : 16'h0000;
  wire [15:0] err_all = err_acc | err_in;
  wire [1:0] rd_kind = rd_ctrl[1:0];
  wire [15:0] rd_len = rd_ctrl[31:16];
  wire rd_long = rd_len > 16'd2;
  wire [5:0] rd_dt = rd_kind[0] ?
      (rd_long ? `DSRT_DT_DCS_LONG : (rd_len == 16'd1 ? `DSRT_DT_DCS_RD1 : `DSRT_DT_DCS_RD2)) :
      (rd_long ? `DSRT_DT_GEN_LONG : (rd_len == 16'd1 ? `DSRT_DT_GEN_RD1 : `DSRT_DT_GEN_RD2));
  wire [15:0] rd_field = rd_long ? rd_len : {rd_word[1], rd_word[0]};
  wire [23:0] rd_h = {rd_field, rd_vc_q, rd_dt};
  wire [23:0] er_h = {err_snap, rd_vc_q, `DSRT_DT_ACK_ERR};
  wire [7:0] pay_byte = (pidx < 16'd4) ? rd_word[pidx[1:0]] : pps_bus.rdata;
  wire start_ok = bta_grant & lp_mode;
  wire tx_err_done = (state == DSRT_ERRPKT) & (bidx == 2'd3);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_acc <= 16'h0000;
    end else if (tx_err_done) begin
      err_acc <= err_in; // new errors win over the clear
    end else begin
      err_acc <= err_all;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= DSRT_IDLE;
      bidx <= 2'd0;
      pidx <= 16'h0000;
      crc <= 16'hFFFF;
      send_err <= 1'b0;
      err_snap <= 16'h0000;
      rd_vc_q <= 2'b00;
      tx_count <= 16'h0000;
    end else begin
      case (state)
        DSRT_IDLE: begin
          bidx <= 2'd0;
          pidx <= 16'h0000;
          crc <= 16'hFFFF;
          err_snap <= err_all;
          rd_vc_q <= rx_vc;
          send_err <= err_all != 16'h0000;
          if (start_ok) begin
            if (rd_pend && (err_all & 16'h0203) == 16'h0000) begin
              state <= DSRT_HDR;
            end else if (err_all != 16'h0000) begin
              state <= DSRT_ERRPKT;
            end
          end
        end
        DSRT_HDR: begin
          bidx <= bidx + 2'd1;
          if (bidx == 2'd3) begin
            state <= rd_long ? DSRT_PAY : (send_err ? DSRT_ERRPKT : DSRT_WAIT);
          end
        end
        DSRT_PAY: begin
          crc <= crc_step(crc, pay_byte);
          pidx <= pidx + 16'd1;
          if (pidx + 16'd1 == rd_len) begin
            state <= DSRT_CKS;
          end
        end
        DSRT_CKS: begin
          bidx <= bidx + 2'd1;
          if (bidx == 2'd1) begin
            bidx <= 2'd0;
            state <= send_err ? DSRT_ERRPKT : DSRT_WAIT;
          end
        end
        DSRT_ERRPKT: begin
          bidx <= bidx + 2'd1;
          if (bidx == 2'd3) begin
            state <= DSRT_WAIT;
          end
        end
        DSRT_WAIT: begin
          tx_count <= tx_count + 16'd1;
          if (!bta_grant) begin
            state <= DSRT_IDLE;
          end
        end
        default: state <= DSRT_IDLE;
      endcase
    end
  end
  assign pps_raddr = PPS_AW'(pidx - 16'd3);
  // byte outputs picked from state
  always_comb begin
    hdr[0] = (state == DSRT_ERRPKT) ? er_h[7:0] : rd_h[7:0];
    hdr[1] = (state == DSRT_ERRPKT) ? er_h[15:8] : rd_h[15:8];
    hdr[2] = (state == DSRT_ERRPKT) ? er_h[23:16] : rd_h[23:16];
    hdr[3] = (state == DSRT_ERRPKT) ? hdr_ecc(er_h) : hdr_ecc(rd_h);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lane0_valid <= 1'b0;
      lane0_byte <= 8'h00;
      lane0_last <= 1'b0;
    end else begin
      lane0_valid <= (state == DSRT_HDR) | (state == DSRT_PAY) |
                     (state == DSRT_CKS) | (state == DSRT_ERRPKT);
      lane0_byte <= (state == DSRT_PAY) ? pay_byte :
                    (state == DSRT_CKS) ? (bidx[0] ? crc[15:8] : crc[7:0]) : hdr[bidx];
      lane0_last <= tx_err_done | ((state == DSRT_HDR) & (bidx == 2'd3) & ~rd_long & ~send_err) |
                    ((state == DSRT_CKS) & (bidx == 2'd1) & ~send_err);
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  logic aw_held, w_held;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  wire do_wr = aw_held & w_held & ~s_axi_bvalid;
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready = ~w_held;
  assign s_axi_arready = ~s_axi_rvalid;
  wire rd_done = (state == DSRT_HDR) & (bidx == 2'd0);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      rd_ctrl <= 32'h00000000;
      rd_pend <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        rd_word[i] <= 8'h00;
      end
    end else begin
      if (s_axi_awvalid & ~aw_held) begin
        aw_held <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_held) begin
        w_held <= 1'b1;
        w_q <= s_axi_wdata;
      end
      if (rd_done) begin
        rd_pend <= 1'b0;
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_q == `DSRT_REG_CTRL || aw_q == `DSRT_REG_RDDATA) ? 2'b00 : 2'b10;
        if (aw_q == `DSRT_REG_CTRL) begin
          rd_ctrl <= {16'(w_q[31:16] > 16'(MAX_RD) ? 16'(MAX_RD) : w_q[31:16]), 14'h0000,
                      w_q[1:0]};
          rd_pend <= w_q[1];
        end
        if (aw_q == `DSRT_REG_RDDATA) begin
          for (int i = 0; i < 4; i++) begin
            rd_word[i] <= w_q[8*i +: 8];
          end
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // read mux
  logic [31:0] next_rdata;
  always_comb begin
    case (s_axi_araddr)
      `DSRT_REG_CTRL: next_rdata = rd_ctrl;
      `DSRT_REG_STATUS: next_rdata = {24'h000000, 3'b000, rd_pend, lck_s[1], tear_sync_output,
                                      state == DSRT_IDLE, decomp_enable};
      `DSRT_REG_ERR: next_rdata = {16'h0000, err_acc};
      `DSRT_REG_RDDATA: next_rdata = {rd_word[3], rd_word[2], rd_word[1], rd_word[0]};
      `DSRT_REG_TEAR: next_rdata = {14'h0000, tear_mode, tear_on, tear_line};
      `DSRT_REG_CMP: next_rdata = {16'h0000, cmp_pend, cmp_live};
      `DSRT_REG_PPS: next_rdata = {24'h000000, 8'(pps_ptr)};
      `DSRT_REG_TX: next_rdata = {16'h0000, tx_count};
      default: next_rdata = 32'h00000000;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid & ~s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= (s_axi_araddr[7:5] == 3'b000 && s_axi_araddr[1:0] == 2'b00) ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // dsrt_response_tear
`default_nettype wire

// ==== verification/dsrt_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------
// host link partner
// ------------------
module dsrt_host_model (
  input wire logic aclk,
  output logic rx_valid,
  output logic [5:0] rx_dtype,
  output logic [1:0] rx_vc,
  output logic [15:0] rx_hdr_data,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_end,
  output logic [15:0] rx_err,
  output logic bta_grant,
  output logic lp_mode,
  output logic lane_clk,
  input wire logic lane0_valid,
  input wire logic [7:0] lane0_byte
);
  logic busy = 1'b0;
  logic [7:0] q[$];
  // idle link in low power
  initial begin
    {rx_valid, rx_byte_valid, rx_end, bta_grant, lane_clk, rx_vc} = '0;
    {rx_dtype, rx_hdr_data, rx_byte, rx_err} = '0;
    lp_mode = 1'b1;
  end
  // link clock toggles only while a packet is sent
  initial begin
    #7;
    forever begin
      #160;
      if (busy) lane_clk = ~lane_clk;
    end
  end
  // collect reverse bytes
  always @(posedge aclk) if (lane0_valid) q.push_back(lane0_byte);
  // header pulse, payload bytes, end pulse; stale lines inverted
  task automatic pkt(input logic [5:0] dt, input logic [15:0] hd, er, input logic [7:0] pl[$]);
    @(posedge aclk);
    busy <= 1'b1;
    rx_valid <= 1'b1;
    {rx_dtype, rx_hdr_data, rx_err} <= {dt, hd, er};
    @(posedge aclk);
    rx_valid <= 1'b0;
    {rx_dtype, rx_hdr_data, rx_err} <= ~{dt, hd, er};
    foreach (pl[i]) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= pl[i];
      @(posedge aclk);
    end
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    rx_end <= 1'b1;
    @(posedge aclk);
    rx_end <= 1'b0;
    busy <= 1'b0;
  endtask
  // hand the bus over until the device goes quiet
  task automatic grant(output int n);
    int idle;
    idle = 0;
    q.delete();
    @(posedge aclk);
    bta_grant <= 1'b1;
    for (int k = 0; k < 80 && idle < 12; k++) begin
      @(posedge aclk);
      idle = lane0_valid ? 0 : idle + 1;
    end
    bta_grant <= 1'b0;
    @(posedge aclk);
    n = q.size();
  endtask
endmodule // dsrt_host_model
`default_nettype wire

// ==== verification/dsrt_props.sv ====
`timescale 1ns/10ps
`default_nettype none
// ---------------------
// reverse link checker
// ---------------------
module dsrt_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rx_valid,
  input wire logic [5:0] rx_dtype,
  input wire logic [15:0] rx_err,
  input wire logic bta_grant,
  input wire logic lp_mode,
  input wire logic vsync,
  input wire logic lane0_valid,
  input wire logic [7:0] lane0_byte,
  input wire logic lane0_last,
  input wire logic tear_sync_output,
  input wire logic decomp_enable,
  input wire logic cmd_discard
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic in_pkt, tear_cmd, vs_q;
  logic [3:0] vs_age;
  wire sop = lane0_valid && !in_pkt;
  wire [5:0] dt = lane0_byte[5:0];
  // packet framing, tear command seen, cycles since vsync
  always_ff @(posedge aclk) begin
    in_pkt <= aresetn && lane0_valid && !lane0_last;
    tear_cmd <= aresetn && (tear_cmd || (rx_valid && rx_dtype inside {6'h15, 6'h39}));
    vs_q <= vsync;
    vs_age <= (!aresetn) ? 4'hF : (vsync && !vs_q) ? 4'h0 : vs_age + {3'h0, vs_age != 4'hF};
  end
  // error report: three bytes after the type, last on the fourth
  sequence rpt_tail;
    (lane0_valid && !lane0_last) [*2] ##1 (lane0_valid && lane0_last);
  endsequence
  sequence rpt_resv;
    !lane0_byte[7] ##1 (lane0_byte[7:5] == 3'h0);
  endsequence
  lane_cond_a: assert property (lane0_valid |-> lp_mode && bta_grant)
    else $error("lane 0 byte outside granted low power");
  resp_type_a: assert property (sop |-> dt inside {6'h02, 6'h11, 6'h12, 6'h1A, 6'h1C, 6'h21, 6'h22})
    else $error("bad response type");
  rpt_len_a: assert property (sop && dt == 6'h02 |=> rpt_tail)
    else $error("error report not four bytes");
  rpt_resv_a: assert property (sop && dt == 6'h02 |=> rpt_resv)
    else $error("reserved error bit set");
  short_len_a: assert property (sop && dt inside {6'h11, 6'h12, 6'h21, 6'h22} |=> lane0_valid [*3])
    else $error("short read response broken");
  tear_idle_a: assert property (!tear_cmd |-> !tear_sync_output)
    else $error("tear output active before enable");
  discard_a: assert property (cmd_discard == (rx_valid && (rx_err[0] || rx_err[1] || rx_err[9])))
    else $error("discard pulse mismatch");
  vsync_apply_a: assert property ($changed(decomp_enable) |-> vs_age <= 4'hA)
    else $error("compression change away from vsync");
endmodule // dsrt_props
`default_nettype wire

// ==== verification/dsrt_response_tear_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dsrt_map.svh"
// ----------
// bench top
// ----------
module dsrt_response_tear_bench;
  logic aclk = 0, aresetn = 0, vsync = 0, hsync = 0, tq = 0, en, pe = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, d, p0;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] r, tbl, algo;
  logic [7:0] pl[$];
  logic [5:0] dts[6] = '{6'h11, 6'h21, 6'h12, 6'h22, 6'h1A, 6'h1C};
  wire rx_valid, rx_byte_valid, rx_end, bta_grant, lp_mode, lane_clk, lane0_valid, lane0_last;
  wire tear_sync_output, decomp_enable, cmd_discard, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid;
  wire [5:0] rx_dtype;
  wire [1:0] rx_vc, decomp_algo, decomp_table, s_axi_bresp, s_axi_rresp;
  wire [15:0] rx_hdr_data, rx_err;
  wire [7:0] rx_byte, lane0_byte;
  wire [31:0] s_axi_rdata;
  int error_cnt = 0, tests_run = 0, cyc = 0, tr = 0, hs = 0, hsr = 0, n, b1, b2;
  dsrt_response_tear dsrt_response_tear_inst (.*);
  dsrt_host_model dsrt_host_model_inst (.*);
  // clock
  initial forever #20 aclk = ~aclk;
  // tear edge counter and run limit
  always @(posedge aclk) begin
    tq <= tear_sync_output;
    if (tear_sync_output && !tq) begin
      tr++;
      hsr = hs;
    end
    cyc++;
    if (cyc > 30000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic chk(input logic [79:0] s, e, input string m);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, s, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // reflected crc, seed all ones, payload lsb first
  function automatic logic [15:0] crc(input logic [23:0] v);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < 24; i++) c = (c >> 1) ^ ((c[0] ^ v[i]) ? 16'h8408 : 16'h0000);
    return c;
  endfunction
  function automatic logic [7:0] qb(input int i);
    return dsrt_host_model_inst.q[i];
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {r, d} = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
  endtask
  task automatic snd(input logic [5:0] dt, input logic [15:0] hd, er);
    dsrt_host_model_inst.pkt(dt, hd, er, pl);
    pl.delete();
  endtask
  // one frame: vsync then six lines
  task automatic frame();
    tr = 0;
    hs = 0;
    vsync <= 1'b1;
    repeat (4) @(posedge aclk);
    vsync <= 1'b0;
    repeat (6) begin
      repeat (8) @(posedge aclk);
      hsync <= 1'b1;
      hs++;
      repeat (4) @(posedge aclk);
      hsync <= 1'b0;
    end
    repeat (12) @(posedge aclk);
  endtask
  // main sequence
  initial begin
    void'($urandom(88));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chk(decomp_enable, 0, "decompression after reset");
    rd(8'h40);
    chk({r, d}, {2'b10, 32'h0}, "unmapped read");
    wr(`DSRT_REG_STATUS, $urandom);
    chk(r, 2'b10, "read-only write");
    frame();
    chk(tr, 0, "tear idle");
    snd(6'h15, 16'h0035, 16'h0);
    frame();
    chk({tr, hsr}, {32'd1, 32'd0}, "vsync only");
    snd(6'h15, 16'h0135, 16'h0);
    frame();
    chk(tr, 7, "vsync and hsync");
    pl = '{8'h44, 8'h00, 8'h03};
    snd(6'h39, 16'h0003, 16'h0);
    frame();
    chk({tr, hsr}, {32'd1, 32'd3}, "line offset pulse");
    snd(6'h05, 16'h0034, 16'h0);
    frame();
    chk(tr, 0, "tear off");
    b1 = 2 + $urandom % 5;
    b2 = 10 + $urandom % 3;
    snd(6'h05, 16'h0, 16'h1 << b1);
    snd(6'h05, 16'h0, 16'h1 << b2);
    dsrt_host_model_inst.grant(n);
    chk({n, qb(0), qb(2), qb(1)}, {32'd4, 8'h02, 16'h1 << b1 | 16'h1 << b2}, "report");
    dsrt_host_model_inst.grant(n);
    chk(n, 0, "report cleared");
    for (int k = 0; k < 6; k++) begin
      wr(`DSRT_REG_RDDATA, $urandom);
      p0 = s_axi_wdata;
      wr(`DSRT_REG_CTRL, {16'(k / 2 + 1), 14'h0, 1'b1, k[0]});
      dsrt_host_model_inst.grant(n);
      chk(qb(0), {2'b00, dts[k]}, "read type");
      chk(qb(1), k < 4 ? p0[7:0] : 8'h03, "first byte");
      if (k / 2 == 1) chk(qb(2), p0[15:8], "second byte");
      if (k < 4) chk(n, 4, "short length");
      else chk({n, qb(6), qb(5), qb(4), qb(8), qb(7)}, {32'd9, p0[23:0], crc(p0[23:0])}, "long");
    end
    wr(`DSRT_REG_CTRL, {16'h1, 16'h2});
    snd(6'h06, 16'h0, 16'h0200);
    dsrt_host_model_inst.grant(n);
    chk({n, qb(0), qb(2)}, {32'd4, 8'h02, 8'h02}, "read withheld");
    wr(`DSRT_REG_CTRL, {16'h1, 16'h2});
    snd(6'h06, 16'h0, 16'h0100);
    dsrt_host_model_inst.grant(n);
    chk({n, qb(4), qb(6)}, {32'd8, 8'h02, 8'h01}, "read then report");
    for (int k = 0; k < 4; k++) begin
      {en, algo, tbl} = {k[0] ^ k[1], {2{k[0]}}, 2'(3 - k)};
      snd(`DSRT_DT_CMP_MODE, {10'h0, tbl, 1'b0, algo, en}, 16'h0);
      repeat (3) @(posedge aclk);
      chk(decomp_enable, pe, "held until vsync");
      frame();
      chk({decomp_table, decomp_algo, decomp_enable}, {tbl, algo, en}, "mode");
      pe = en;
      if (en) begin
        pl = '{8'h5A};
        snd(`DSRT_DT_CMP_PIX, 16'h0001, 16'h0);
        chk(decomp_enable, en, "pixel stream");
      end
    end
    rd(`DSRT_REG_PPS);
    p0 = d;
    pl = '{8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
    snd(`DSRT_DT_PPS, 16'h0004, 16'h0);
    rd(`DSRT_REG_PPS);
    chk(d - p0, 4, "table write");
    conclude();
  end
endmodule // dsrt_response_tear_bench
bind dsrt_response_tear dsrt_props dsrt_props_inst (.aclk, .aresetn, .rx_valid, .rx_dtype,
  .rx_err, .bta_grant, .lp_mode, .vsync, .lane0_valid, .lane0_byte, .lane0_last,
  .tear_sync_output, .decomp_enable, .cmd_discard);
`default_nettype wire
